// [inc/ssp_regs.svh]
/*
  register offsets, field positions, reset values and timing counts of the
  strap sampling and status pin block. assumes a 200 MHz core clock.
*/
// Behaviour
// - low reset forces all logic to defaults
// - select high picks first clock, low second
// - input rate straps loaded into both configs
// - open input rate straps give 8 kHz
// - single-ended rate straps sampled, open gives 19.44MHz
// - differential rate straps sampled, open gives 38.88MHz
// - two-bit field selects differential signal format
// - frame sync 50% clock, invert and pulse bits
// - multiframe sync 50% clock, own invert/pulse bits
// - failure pin follows status when enabled, else undriven
// - lock pin shows lock when enabled, else low
// - differential strap pins become general purpose io
`ifndef SSP_REGS_SVH
`define SSP_REGS_SVH

`define SSP_ADDR_W          6
`define SSP_OFS_IN1_CFG     6'h00
`define SSP_OFS_IN2_CFG     6'h04
`define SSP_OFS_OUT_RATE    6'h08
`define SSP_OFS_MCFG8       6'h0C
`define SSP_OFS_FP_CFG      6'h10
`define SSP_OFS_MCFG10      6'h14
`define SSP_OFS_MCFG1       6'h18
`define SSP_OFS_IO_CTRL     6'h1C
`define SSP_OFS_IO_STATE    6'h20
`define SSP_OFS_MSTS2       6'h24
`define SSP_OFS_IRQ_STS     6'h28
`define SSP_OFS_IRQ_MASK    6'h2C

// field positions
`define SSP_FP_INV_BIT      0
`define SSP_FP_PUL_BIT      1
`define SSP_MF_INV_BIT      2
`define SSP_MF_PUL_BIT      3
`define SSP_DIFF_RATE_LSB   4
`define SSP_IO_VAL_LSB      4
`define SSP_EV_FAIL         0
`define SSP_EV_UNLOCK       1
`define SSP_EV_SWITCH       2

// reset values and strap codes
`define SSP_IN_RATE_8K      4'h0
`define SSP_SE_RATE_OPEN    3'h3
`define SSP_DIFF_RATE_OPEN  3'h4
`define SSP_FMT_RST         2'h0
`define SSP_FP_CFG_RST      4'h0

// timing
`define SSP_CLK_HZ          200000000
`define SSP_FRAME_HZ        8000
`define SSP_MFRAME_HZ       2000
`define SSP_FRAME_CYCLES    (`SSP_CLK_HZ / `SSP_FRAME_HZ)
`define SSP_MF_FRAMES       (`SSP_FRAME_HZ / `SSP_MFRAME_HZ)

`endif

// [inc/ssp_pkg.sv]
/*
  types of the strap sampling and status pin block.
  assumes ssp_regs.svh for field widths elsewhere.
*/
package ssp_pkg;

  typedef struct packed {
    logic [2:0] in_rate;
    logic [2:0] se_rate;
    logic [2:0] diff_rate;
  } ssp_strap_t;

  typedef struct packed {
    logic       fail_o;
    logic       fail_oe;
    logic       lock_o;
    logic       lock_oe;
    logic [2:0] io_o;
    logic [2:0] io_oe;
  } ssp_pin_out_t;

  typedef struct packed {
    logic         strapped;
    logic [3:0]   in_rate1;
    logic [3:0]   in_rate2;
    logic [2:0]   se_rate;
    logic [2:0]   diff_rate;
    logic [1:0]   sig_fmt;
    logic [3:0]   fp_cfg;
    logic         fail_en;
    logic         lock_en;
    logic [2:0]   io_dir;
    logic [2:0]   io_val;
    logic [2:0]   io_lvl;
    logic [2:0]   sts;
    logic [2:0]   mask;
    logic         sel_first;
    logic         fail_q;
    logic         lock_q;
    logic [31:0]  frm_cnt;
    logic [1:0]   mf_cnt;
    logic         frame_out;
    logic         mf_out;
    logic         irq;
    logic         waitreq;
    logic [31:0]  rdata;
    ssp_pin_out_t pins;
  } ssp_state_t;

endpackage : ssp_pkg

// [verilog/ssp_top.sv]
/*
  strap capture at reset release, shared status / io pins, source select,
  frame and multiframe sync outputs and an avalon-mm register slave.
  assumes all inputs synchronous to core_clk; pins resolved outside.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ssp_regs.svh"

module ssp_top #(
  parameter int unsigned FRAME_CYCLES = `SSP_FRAME_CYCLES
) (
  input  wire logic                      core_clk,
  input  wire logic                      rst_b,
  input  wire logic [`SSP_ADDR_W-1:0]    avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  output logic [31:0]                    avs_readdata,
  output logic                           avs_waitrequest,
  input  wire ssp_pkg::ssp_strap_t       straps,
  input  wire logic                      source_select_pin,
  input  wire logic                      reference_failure,
  input  wire logic                      dpll_locked,
  output ssp_pkg::ssp_pin_out_t          pin_out,
  output logic                           select_first_input,
  output logic [3:0]                     first_input_rate,
  output logic [3:0]                     second_input_rate,
  output logic [2:0]                     se_output_rate,
  output logic [2:0]                     diff_output_rate,
  output logic [1:0]                     diff_signal_format,
  output logic                           frame_pulse_out,
  output logic                           multiframe_pulse_out,
  output logic                           irq
);

  localparam logic [31:0] FRAME_LAST = 32'(FRAME_CYCLES - 1);
  localparam logic [31:0] FRAME_HALF = 32'(FRAME_CYCLES / 2);
  localparam logic [1:0]  MF_LAST    = 2'(`SSP_MF_FRAMES - 1);
  localparam logic [1:0]  MF_HALF    = 2'(`SSP_MF_FRAMES / 2);

  ssp_pkg::ssp_state_t st;
  ssp_pkg::ssp_state_t next_st;

  logic       acc;
  logic       wr;
  logic [2:0] ev;
  logic       frm_wrap;
  logic       frm_high;
  logic       mf_high;

  always_comb begin
    next_st  = st;
    acc      = (avs_read | avs_write) & st.waitreq;
    wr       = avs_write & ~st.waitreq;
    frm_wrap = (st.frm_cnt >= FRAME_LAST);
    ev       = 3'h0;

    // capture straps once, the cycle after release
    if (!st.strapped) begin
      next_st.strapped  = 1'b1;
      next_st.in_rate1  = {1'b0, straps.in_rate};
      next_st.in_rate2  = {1'b0, straps.in_rate};
      next_st.se_rate   = straps.se_rate;
      next_st.diff_rate = straps.diff_rate;
    end

    next_st.sel_first = source_select_pin;
    next_st.fail_q    = reference_failure;
    next_st.lock_q    = dpll_locked;
    next_st.io_lvl    = {straps.diff_rate[2], straps.diff_rate[1], straps.diff_rate[0]};

    // events
    ev[`SSP_EV_FAIL]   = reference_failure & ~st.fail_q;
    ev[`SSP_EV_UNLOCK] = st.lock_q & ~dpll_locked;
    ev[`SSP_EV_SWITCH] = source_select_pin ^ st.sel_first;

    // bus slave: one wait cycle, then answer
    next_st.waitreq = ~acc;
    if (acc) begin
      case (avs_address)
        `SSP_OFS_IN1_CFG:  next_st.rdata = {28'h0, st.in_rate1};
        `SSP_OFS_IN2_CFG:  next_st.rdata = {28'h0, st.in_rate2};
        `SSP_OFS_OUT_RATE: next_st.rdata = {25'h0, st.diff_rate, 1'b0, st.se_rate};
        `SSP_OFS_MCFG8:    next_st.rdata = {30'h0, st.sig_fmt};
        `SSP_OFS_FP_CFG:   next_st.rdata = {28'h0, st.fp_cfg};
        `SSP_OFS_MCFG10:   next_st.rdata = {31'h0, st.fail_en};
        `SSP_OFS_MCFG1:    next_st.rdata = {31'h0, st.lock_en};
        `SSP_OFS_IO_CTRL:  next_st.rdata = {25'h0, st.io_val, 1'b0, st.io_dir};
        `SSP_OFS_IO_STATE: next_st.rdata = {29'h0, st.io_lvl};
        `SSP_OFS_MSTS2:    next_st.rdata = {29'h0, st.sel_first, st.lock_q, st.fail_q};
        `SSP_OFS_IRQ_STS:  next_st.rdata = {29'h0, st.sts};
        `SSP_OFS_IRQ_MASK: next_st.rdata = {29'h0, st.mask};
        default:           next_st.rdata = 32'h0;
      endcase
    end

    if (wr) begin
      case (avs_address)
        `SSP_OFS_IN1_CFG:  next_st.in_rate1 = avs_writedata[3:0];
        `SSP_OFS_IN2_CFG:  next_st.in_rate2 = avs_writedata[3:0];
        `SSP_OFS_OUT_RATE: begin
          next_st.se_rate   = avs_writedata[2:0];
          next_st.diff_rate = avs_writedata[`SSP_DIFF_RATE_LSB +: 3];
        end
        `SSP_OFS_MCFG8:    next_st.sig_fmt = avs_writedata[1:0];
        `SSP_OFS_FP_CFG:   next_st.fp_cfg  = avs_writedata[3:0];
        `SSP_OFS_MCFG10:   next_st.fail_en = avs_writedata[0];
        `SSP_OFS_MCFG1:    next_st.lock_en = avs_writedata[0];
        `SSP_OFS_IO_CTRL:  begin
          next_st.io_dir = avs_writedata[2:0];
          next_st.io_val = avs_writedata[`SSP_IO_VAL_LSB +: 3];
        end
        `SSP_OFS_IRQ_MASK: next_st.mask = avs_writedata[2:0];
        default:           next_st.mask = st.mask;
      endcase
    end

    // sticky status, set wins over write-one-clear
    if (wr && avs_address == `SSP_OFS_IRQ_STS) begin
      next_st.sts = (st.sts & ~avs_writedata[2:0]) | ev;
    end else begin
      next_st.sts = st.sts | ev;
    end
    next_st.irq = |(next_st.sts & next_st.mask);

    // frame and multiframe timing
    if (frm_wrap) begin
      next_st.frm_cnt = 32'h0;
      next_st.mf_cnt  = (st.mf_cnt >= MF_LAST) ? 2'h0 : st.mf_cnt + 2'h1;
    end else begin
      next_st.frm_cnt = st.frm_cnt + 32'h1;
    end
    frm_high = st.fp_cfg[`SSP_FP_PUL_BIT] ? (st.frm_cnt == 32'h0)
                                          : (st.frm_cnt < FRAME_HALF);
    mf_high  = st.fp_cfg[`SSP_MF_PUL_BIT] ? (st.frm_cnt == 32'h0 && st.mf_cnt == 2'h0)
                                          : (st.mf_cnt < MF_HALF);
    next_st.frame_out = frm_high ^ st.fp_cfg[`SSP_FP_INV_BIT];
    next_st.mf_out    = mf_high ^ st.fp_cfg[`SSP_MF_INV_BIT];

    // shared pins take their second role only after straps are taken
    next_st.pins.fail_o  = reference_failure;
    next_st.pins.fail_oe = st.strapped & st.fail_en;
    next_st.pins.lock_o  = st.lock_en & dpll_locked;
    next_st.pins.lock_oe = st.strapped;
    next_st.pins.io_o    = st.io_val;
    next_st.pins.io_oe   = st.strapped ? st.io_dir : 3'h0;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st           <= '0;
      st.waitreq   <= 1'b1;
      st.in_rate1  <= `SSP_IN_RATE_8K;
      st.in_rate2  <= `SSP_IN_RATE_8K;
      st.se_rate   <= `SSP_SE_RATE_OPEN;
      st.diff_rate <= `SSP_DIFF_RATE_OPEN;
      st.sig_fmt   <= `SSP_FMT_RST;
      st.fp_cfg    <= `SSP_FP_CFG_RST;
    end else begin
      st <= next_st;
    end
  end

  assign avs_readdata         = st.rdata;
  assign avs_waitrequest      = st.waitreq;
  assign pin_out              = st.pins;
  assign select_first_input   = st.sel_first;
  assign first_input_rate     = st.in_rate1;
  assign second_input_rate    = st.in_rate2;
  assign se_output_rate       = st.se_rate;
  assign diff_output_rate     = st.diff_rate;
  assign diff_signal_format   = st.sig_fmt;
  assign frame_pulse_out      = st.frame_out;
  assign multiframe_pulse_out = st.mf_out;
  assign irq                  = st.irq;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  AST_SELECT: assert property (
    st.strapped |=> select_first_input == $past(source_select_pin))
    else $error("source select not followed");

  AST_IN_STRAP: assert property (
    $rose(st.strapped) |-> first_input_rate == {1'b0, $past(straps.in_rate)}
                           && second_input_rate == first_input_rate)
    else $error("input rate straps not loaded");

  AST_IN_OPEN: assert property (
    $rose(st.strapped) && $past(straps.in_rate) == 3'h0
      |-> first_input_rate == `SSP_IN_RATE_8K)
    else $error("open input straps not 8 kHz");

  AST_SE_STRAP: assert property (
    $rose(st.strapped) |-> se_output_rate == $past(straps.se_rate))
    else $error("single-ended rate straps not loaded");

  AST_DIFF_STRAP: assert property (
    $rose(st.strapped) |-> diff_output_rate == $past(straps.diff_rate))
    else $error("differential rate straps not loaded");

  AST_FMT_WR: assert property (
    avs_write && !avs_waitrequest && avs_address == `SSP_OFS_MCFG8
      |=> diff_signal_format == $past(avs_writedata[1:0]))
    else $error("signal format write lost");

  AST_FRAME_CLK: assert property (
    st.fp_cfg == 4'h0 && st.frm_cnt == 32'h1 ##1 st.fp_cfg == 4'h0
      |-> frame_pulse_out && $past(frame_pulse_out))
    else $error("frame sync not high at frame start");

  AST_MF_INV: assert property (
    st.fp_cfg == 4'h4 && st.mf_cnt == 2'h0 && st.frm_cnt == 32'h4
      |=> !multiframe_pulse_out)
    else $error("multiframe invert not applied");

  AST_FAIL_PIN: assert property (
    st.strapped && st.fail_en |=> pin_out.fail_oe && pin_out.fail_o == $past(reference_failure))
    else $error("failure pin not following status");

  AST_LOCK_PIN: assert property (
    st.strapped |=> pin_out.lock_oe && pin_out.lock_o == ($past(st.lock_en) && $past(dpll_locked)))
    else $error("lock pin wrong");

  AST_IO_DIR: assert property (
    st.strapped |=> pin_out.io_oe == $past(st.io_dir) && pin_out.io_o == $past(st.io_val))
    else $error("io pin control wrong");

  AST_NO_DRIVE: assert property (
    !st.strapped |-> !pin_out.fail_oe && !pin_out.lock_oe && pin_out.io_oe == 3'h0)
    else $error("strap pin driven before capture");

  AST_RST_DEFAULT: assert property (
    @(posedge core_clk) disable iff (1'b0)
    !rst_b && $past(!rst_b) |-> avs_waitrequest && !irq && !frame_pulse_out
                                && first_input_rate == `SSP_IN_RATE_8K
                                && se_output_rate == `SSP_SE_RATE_OPEN
                                && diff_output_rate == `SSP_DIFF_RATE_OPEN)
    else $error("defaults not held in reset");

  AST_RST_NO_DRIVE: assert property (
    @(posedge core_clk) disable iff (1'b0)
    !rst_b && $past(!rst_b) |-> !pin_out.fail_oe && !pin_out.lock_oe && pin_out.io_oe == 3'h0)
    else $error("strap pin driven during reset");

  AST_STRAP_IGNORED: assert property (
    st.strapped && !(avs_write && !avs_waitrequest)
      |=> $stable(first_input_rate) && $stable(second_input_rate)
          && $stable(se_output_rate) && $stable(diff_output_rate))
    else $error("rate changed without a register write");

  AST_SE_OPEN: assert property (
    $rose(st.strapped) && $past(straps.se_rate) == `SSP_SE_RATE_OPEN
      |-> se_output_rate == `SSP_SE_RATE_OPEN)
    else $error("open single-ended straps not default rate");

  AST_DIFF_OPEN: assert property (
    $rose(st.strapped) && $past(straps.diff_rate) == `SSP_DIFF_RATE_OPEN
      |-> diff_output_rate == `SSP_DIFF_RATE_OPEN)
    else $error("open differential straps not default rate");

  AST_FMT_HOLD: assert property (
    !(avs_write && !avs_waitrequest && avs_address == `SSP_OFS_MCFG8)
      |=> $stable(diff_signal_format))
    else $error("signal format changed without a write");

  AST_FRAME_PULSE: assert property (
    st.fp_cfg[`SSP_FP_PUL_BIT] && !st.fp_cfg[`SSP_FP_INV_BIT]
      |=> frame_pulse_out == ($past(st.frm_cnt) == 32'h0))
    else $error("frame pulse not one cycle at frame start");

  AST_FRAME_INV: assert property (
    st.fp_cfg == 4'h1 && st.frm_cnt == 32'h0 |=> !frame_pulse_out)
    else $error("frame invert not applied");

  AST_MF_PULSE: assert property (
    st.fp_cfg[`SSP_MF_PUL_BIT] && !st.fp_cfg[`SSP_MF_INV_BIT] && st.mf_cnt != 2'h0
      |=> !multiframe_pulse_out)
    else $error("multiframe pulse outside first frame");

  AST_FAIL_OFF: assert property (
    st.strapped && !st.fail_en |=> !pin_out.fail_oe)
    else $error("failure pin driven while disabled");

  AST_LOCK_OFF: assert property (
    st.strapped && !st.lock_en |=> pin_out.lock_oe && !pin_out.lock_o)
    else $error("lock pin not low while disabled");

  AST_IO_LEVEL: assert property (
    avs_read && avs_waitrequest && avs_address == `SSP_OFS_IO_STATE
      |=> avs_readdata == {29'h0, $past(st.io_lvl)})
    else $error("io state read wrong");

  AST_EV_FAIL: assert property (
    reference_failure && !st.fail_q |=> st.sts[`SSP_EV_FAIL])
    else $error("failure event not recorded");

  AST_EV_UNLOCK: assert property (
    st.lock_q && !dpll_locked |=> st.sts[`SSP_EV_UNLOCK])
    else $error("lock loss event not recorded");

  AST_EV_SWITCH: assert property (
    source_select_pin != st.sel_first |=> st.sts[`SSP_EV_SWITCH])
    else $error("select change event not recorded");

endmodule : ssp_top

`default_nettype wire

// [verification/ssp_board.sv]
/*
  board model: strap resistor levels and the wired level of each shared pin.
  assumes the bench sets the resistor levels and the design drives pin_out.
*/
`timescale 1ns/1ps
`default_nettype none

module ssp_board (
  input  wire logic [8:0]            strap_lvl,
  input  wire ssp_pkg::ssp_pin_out_t pin_out,
  output ssp_pkg::ssp_strap_t        straps
);
  // a driven pin overrides its resistor, an undriven pin shows the resistor
  always_comb begin
    straps = strap_lvl;
    if (pin_out.fail_oe) straps.se_rate[1] = pin_out.fail_o;
    if (pin_out.lock_oe) straps.se_rate[2] = pin_out.lock_o;
    for (int i = 0; i < 3; i++) begin
      if (pin_out.io_oe[i]) straps.diff_rate[i] = pin_out.io_o[i];
    end
  end
endmodule : ssp_board

`default_nettype wire

// [verification/ssp_top_tb.sv]
/*
  self-checking bench of the strap sampling and status pin block.
  assumes ssp_board as the far side and a 200 MHz core clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ssp_regs.svh"

module ssp_top_tb;
  localparam int FC = 16;
  logic                  core_clk, rst_b, avs_read, avs_write, avs_waitrequest;
  logic                  src_sel, ref_fail, locked, sel1, frm, mfr, irq;
  logic [5:0]            avs_address;
  logic [31:0]           avs_writedata, avs_readdata, rdat;
  logic [8:0]            strap_lvl;
  logic [3:0]            r1, r2;
  logic [2:0]            rse, rdf;
  logic [1:0]            fmt;
  ssp_pkg::ssp_strap_t   straps;
  ssp_pkg::ssp_pin_out_t pin_out;
  int                    n_fail, n_tests;

  ssp_board i_ssp_board (.strap_lvl(strap_lvl), .pin_out(pin_out), .straps(straps));
  ssp_top #(.FRAME_CYCLES(FC)) i_ssp_top (
    .core_clk(core_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .straps(straps), .source_select_pin(src_sel),
    .reference_failure(ref_fail), .dpll_locked(locked), .pin_out(pin_out),
    .select_first_input(sel1), .first_input_rate(r1), .second_input_rate(r2),
    .se_output_rate(rse), .diff_output_rate(rdf), .diff_signal_format(fmt),
    .frame_pulse_out(frm), .multiframe_pulse_out(mfr), .irq(irq));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rdat = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge core_clk);
  endtask : bus

  function automatic logic [31:0] highs(input logic inv, input logic pul, input int x);
    return inv ? 4 * FC - (pul ? x : 2 * FC) : (pul ? x : 2 * FC);
  endfunction : highs

  task automatic do_reset(input logic [8:0] lvl);
    rst_b     <= 1'b0;
    strap_lvl <= lvl;
    repeat (16) @(posedge core_clk);
    check("oe in reset", {pin_out.fail_oe, pin_out.lock_oe, pin_out.io_oe}, 0);
    check("rates in reset", {r1, r2, rse, rdf, fmt}, {8'h00, 3'h3, 3'h4, 2'h0});
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    check("in rates", {r1, r2}, {1'b0, lvl[8:6], 1'b0, lvl[8:6]});
    check("se rate", rse, lvl[5:3]);
    check("diff rate", rdf, lvl[2:0]);
  endtask : do_reset

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  initial begin : watchdog
    repeat (20000) @(posedge core_clk);
    n_fail++;
    tally_and_finish();
  end

  initial begin : main
    logic [31:0] v, lv, fh, mh;
    {rst_b, avs_read, avs_write, src_sel, ref_fail, locked} = 6'h00;
    {avs_address, avs_writedata, strap_lvl} = '0;
    n_fail = 0;
    n_tests = 0;
    void'($urandom(32'h20f3));
    @(posedge core_clk);
    do_reset(9'b000_011_100);
    lv = $urandom;
    do_reset(lv[8:0]);
    strap_lvl <= ~lv[8:0];
    repeat (4) @(posedge core_clk);
    check("straps ignored", {r1, rse, rdf}, {1'b0, lv[8:0]});
    $display("test straps done");
    repeat (8) begin
      v = $urandom;
      src_sel <= v[0];
      repeat (2) @(posedge core_clk);
      check("select", sel1, v[0]);
    end
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, `SSP_OFS_MCFG8, i);
      @(posedge core_clk);
      check("format", fmt, i[1:0]);
    end
    for (int en = 0; en < 2; en++) begin
      bus(1'b1, `SSP_OFS_MCFG10, en);
      bus(1'b1, `SSP_OFS_MCFG1, 1 - en);
      repeat (6) begin
        v = $urandom;
        ref_fail <= v[0];
        locked   <= v[1];
        repeat (4) @(posedge core_clk);
        check("fail oe", pin_out.fail_oe, en[0]);
        if (en == 1) check("fail pin", pin_out.fail_o, v[0]);
        check("lock pin", {pin_out.lock_oe, pin_out.lock_o}, {1'b1, ~en[0] & v[1]});
      end
    end
    $display("test pins done");
    repeat (6) begin
      v = $urandom;
      lv = $urandom;
      strap_lvl <= lv[8:0];
      bus(1'b1, `SSP_OFS_IO_CTRL, v & 32'h77);
      repeat (2) @(posedge core_clk);
      bus(1'b0, `SSP_OFS_IO_STATE, 0);
      check("io oe", pin_out.io_oe, v[2:0]);
      check("io out", pin_out.io_o & v[2:0], v[6:4] & v[2:0]);
      check("io state", rdat, (v[6:4] & v[2:0]) | (lv[2:0] & ~v[2:0]));
    end
    ref_fail <= 1'b0;
    bus(1'b1, `SSP_OFS_IRQ_STS, 32'h7);
    bus(1'b1, `SSP_OFS_IRQ_MASK, 32'h1);
    ref_fail <= 1'b1;
    repeat (4) @(posedge core_clk);
    check("irq raised", irq, 1'b1);
    bus(1'b0, `SSP_OFS_IRQ_STS, 0);
    check("irq status", rdat[0], 1'b1);
    bus(1'b1, `SSP_OFS_IRQ_STS, 32'h1);
    @(posedge core_clk);
    check("irq cleared", irq, 1'b0);
    bus(1'b1, `SSP_OFS_IRQ_MASK, 0);
    ref_fail <= 1'b0;
    @(posedge core_clk);
    ref_fail <= 1'b1;
    repeat (4) @(posedge core_clk);
    check("irq masked", irq, 1'b0);
    bus(1'b0, `SSP_OFS_IRQ_STS, 0);
    check("masked status", rdat[0], 1'b1);
    bus(1'b1, `SSP_OFS_IRQ_STS, 32'h7);
    src_sel <= ~src_sel;
    locked  <= 1'b1;
    repeat (2) @(posedge core_clk);
    locked <= 1'b0;
    repeat (2) @(posedge core_clk);
    bus(1'b0, `SSP_OFS_IRQ_STS, 0);
    check("events", rdat, 32'h6);
    bus(1'b0, `SSP_OFS_MSTS2, 0);
    check("status pins", rdat, {29'h0, src_sel, 2'b01});
    v = $urandom;
    bus(1'b1, `SSP_OFS_IN1_CFG, v);
    bus(1'b1, `SSP_OFS_IN2_CFG, v >> 4);
    bus(1'b1, `SSP_OFS_OUT_RATE, v >> 8);
    bus(1'b0, `SSP_OFS_OUT_RATE, 0);
    check("rate regs", {r1, r2, rse, rdf}, {v[3:0], v[7:4], v[10:8], v[14:12]});
    check("rate read", rdat, v[14:8] & 32'h77);
    bus(1'b0, 6'h30, 0);
    check("unmapped", rdat, 0);
    $display("test irq done");
    for (int c = 0; c < 16; c++) begin
      bus(1'b1, `SSP_OFS_FP_CFG, c);
      repeat (4) @(posedge core_clk);
      fh = 0;
      mh = 0;
      repeat (4 * FC) begin
        @(posedge core_clk);
        fh += frm;
        mh += mfr;
      end
      check("frame highs", fh, highs(c[0], c[1], 4));
      check("mf highs", mh, highs(c[2], c[3], 1));
    end
    $display("test sync done");
    lv = $urandom;
    do_reset(lv[8:0]);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule : ssp_top_tb

`default_nettype wire
